/* File: pm_map_pkg.sv */
// constants and types for the program memory map and boot decode
package pm_map_pkg;

  // ****************************************************************
  // program address space
  // ****************************************************************
  localparam int unsigned PM_AW = 14;
  localparam int unsigned PM_DW = 24;
  localparam logic [13:0] RAM_BASE = 14'h0000;
  localparam logic [13:0] RAM_LAST = 14'h07ff;
  localparam logic [13:0] ROM_BASE = 14'h0800;
  localparam logic [13:0] ROM_LAST = 14'h0fff;
  localparam logic [13:0] EXT_BASE = 14'h1000;
  localparam logic [13:0] RAM_BOOT_START = 14'h0000;
  localparam logic [13:0] ROM_BOOT_START = 14'h0800;

  // ****************************************************************
  // register map: word indices, byte addresses, reset values
  // ****************************************************************
  localparam logic [13:0] WAIT_CTRL_IDX = 14'h3ffe;
  localparam logic [13:0] STATUS_IDX = 14'h3fff;
  localparam logic [15:0] WAIT_CTRL_ADDR = 16'hfff8;
  localparam logic [15:0] STATUS_ADDR = 16'hfffc;
  localparam logic [15:0] WAIT_CTRL_RST = 16'h0000;
  localparam int unsigned ROM_SEL_POS = 15;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ****************************************************************
  // boot loader
  // ****************************************************************
  localparam logic [1:0] BOOT_LAST_BYTE = 2'h2;
  localparam logic [10:0] BOOT_LAST_WORD = 11'h7ff;
  localparam logic [13:0] BOOT_BYTE_BASE = 14'h0000;

  typedef enum logic [1:0] {
    TGT_NONE = 2'b00,
    TGT_RAM = 2'b01,
    TGT_ROM = 2'b10,
    TGT_EXT = 2'b11
  } target_t;

  typedef enum logic [2:0] {
    BOOT_IDLE = 3'b000,
    BOOT_REQ = 3'b001,
    BOOT_WAIT = 3'b010,
    BOOT_WRITE = 3'b011,
    BOOT_DONE = 3'b100
  } boot_state_t;

endpackage

/* File: pm_addr_decode.sv */
// program address to memory target decode
`timescale 1ns/1ps
`default_nettype none
module pm_addr_decode (
  input wire logic [13:0] i_addr, // program address
  input wire logic i_rom_select_bit, // rom window enable
  output var pm_map_pkg::target_t o_target // selected memory
);

  // ****************************************************************
  // decode
  // ****************************************************************
  // rom window only answers while the select bit is set
  always_comb begin
    if (i_addr <= pm_map_pkg::RAM_LAST) begin
      o_target = pm_map_pkg::TGT_RAM;
    end else if (i_addr <= pm_map_pkg::ROM_LAST) begin
      if (i_rom_select_bit) begin
        o_target = pm_map_pkg::TGT_ROM;
      end else begin
        o_target = pm_map_pkg::TGT_EXT;
      end
    end else begin
      o_target = pm_map_pkg::TGT_EXT;
    end
  end

endmodule // pm_addr_decode
`default_nettype wire

/* File: pm_boot_loader.sv */
// byte-wide boot loader that fills internal program ram
`timescale 1ns/1ps
`default_nettype none
module pm_boot_loader (
  input wire logic i_core_clk, // core clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic i_start, // one-cycle start pulse
  input wire logic i_ack, // external byte returned
  input wire logic [7:0] i_byte, // external byte data
  output logic o_rd, // byte read strobe
  output logic [13:0] o_byte_addr, // external byte address
  output logic o_we, // ram word write strobe
  output logic [10:0] o_word_addr, // ram word address
  output logic [23:0] o_word, // assembled word
  output logic o_done // load complete, level
);

  // ****************************************************************
  // state
  // ****************************************************************
  pm_map_pkg::boot_state_t state_q, state_d;
  logic [13:0] baddr_q, baddr_d;
  logic [10:0] waddr_q, waddr_d;
  logic [1:0] bidx_q, bidx_d;
  logic [23:0] word_q, word_d;

  // next state: three bytes per word, first byte is the top byte
  always_comb begin
    state_d = state_q;
    baddr_d = baddr_q;
    waddr_d = waddr_q;
    bidx_d = bidx_q;
    word_d = word_q;
    case (state_q)
      pm_map_pkg::BOOT_IDLE: begin
        if (i_start) begin
          state_d = pm_map_pkg::BOOT_REQ;
        end
      end
      pm_map_pkg::BOOT_REQ: begin
        state_d = pm_map_pkg::BOOT_WAIT;
      end
      pm_map_pkg::BOOT_WAIT: begin
        if (i_ack) begin
          word_d = {word_q[15:0], i_byte};
          baddr_d = baddr_q + 14'h0001;
          if (bidx_q == pm_map_pkg::BOOT_LAST_BYTE) begin
            bidx_d = 2'h0;
            state_d = pm_map_pkg::BOOT_WRITE;
          end else begin
            bidx_d = bidx_q + 2'h1;
            state_d = pm_map_pkg::BOOT_REQ;
          end
        end
      end
      pm_map_pkg::BOOT_WRITE: begin
        waddr_d = waddr_q + 11'h001;
        if (waddr_q == pm_map_pkg::BOOT_LAST_WORD) begin
          state_d = pm_map_pkg::BOOT_DONE;
        end else begin
          state_d = pm_map_pkg::BOOT_REQ;
        end
      end
      pm_map_pkg::BOOT_DONE: begin
        state_d = pm_map_pkg::BOOT_DONE;
      end
      default: begin
        state_d = pm_map_pkg::BOOT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= pm_map_pkg::BOOT_IDLE;
      baddr_q <= pm_map_pkg::BOOT_BYTE_BASE;
      waddr_q <= 11'h000;
      bidx_q <= 2'h0;
      word_q <= 24'h00_0000;
    end else begin
      state_q <= state_d;
      baddr_q <= baddr_d;
      waddr_q <= waddr_d;
      bidx_q <= bidx_d;
      word_q <= word_d;
    end
  end

  // the parent registers these before they reach a pin
  assign o_rd = (state_q == pm_map_pkg::BOOT_REQ);
  assign o_byte_addr = baddr_q;
  assign o_we = (state_q == pm_map_pkg::BOOT_WRITE);
  assign o_word_addr = waddr_q;
  assign o_word = word_q;
  assign o_done = (state_q == pm_map_pkg::BOOT_DONE);

endmodule // pm_boot_loader
`default_nettype wire

/* File: program_memory_map_decode.sv */
// program memory map, rom select register and boot mode decode
//
// Function
// - rom select set: rom range goes to rom
// - rom select clear: rom range goes external
// - reset clears rom select unless both straps
// - rom select lives in wait control register
// - 2K word rom reachable only when selected
// - straps zero: ram at 0x0000, byte-wide boot
// - straps zero: fetch starts 0x0000 after boot
// - straps zero: 0x1000 upward goes external
// - straps one: same map, rom select set
// - straps one: execution starts at rom 0x0800
`timescale 1ns/1ps
`default_nettype none
module program_memory_map_decode (
  input wire logic i_core_clk, // core clock, 50 MHz
  input wire logic i_rst_b, // async reset, active low
  // straps
  input wire logic i_memory_map_strap, // map select strap
  input wire logic i_boot_source_strap, // boot mode strap
  // ahb-lite slave
  input wire logic i_hsel, // slave select
  input wire logic [15:0] i_haddr, // byte address
  input wire logic [1:0] i_htrans, // transfer type
  input wire logic i_hwrite, // write not read
  input wire logic [2:0] i_hsize, // transfer size
  input wire logic [31:0] i_hwdata, // write data
  input wire logic i_hready, // bus ready
  output logic [31:0] o_hrdata, // read data
  output logic o_hreadyout, // slave ready
  output logic o_hresp, // always okay
  // core program memory request
  input wire logic i_pm_req, // access strobe
  input wire logic [13:0] i_pm_addr, // program address
  input wire logic i_pm_wr, // write not read
  input wire logic [23:0] i_pm_wdata, // write data
  // memory side
  output logic o_ram_en, // internal ram strobe
  output logic o_rom_en, // internal rom strobe
  output logic o_ext_en, // external memory strobe
  output logic o_boot_en, // external boot byte strobe
  output logic o_mem_wr, // write not read
  output logic [13:0] o_mem_addr, // memory address
  output logic [23:0] o_mem_wdata, // write data
  input wire logic i_ext_ack, // external byte returned
  input wire logic [7:0] i_ext_byte, // external byte data
  // core sequencer
  output logic o_core_run, // core may fetch
  output logic [13:0] o_start_addr // first fetch address
);

  // ****************************************************************
  // strap capture
  // ****************************************************************
  logic cap_done_q, cap_done_d;
  logic rom_boot_q, rom_boot_d;
  logic [1:0] straps_q, straps_d;

  // straps sampled by the clock on the first edge after release,
  // never loaded under the asynchronous reset itself
  always_comb begin
    cap_done_d = 1'b1;
    straps_d = straps_q;
    rom_boot_d = rom_boot_q;
    if (!cap_done_q) begin
      straps_d = {i_memory_map_strap, i_boot_source_strap};
      rom_boot_d = i_memory_map_strap & i_boot_source_strap;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cap_done_q <= 1'b0;
      straps_q <= 2'b00;
      rom_boot_q <= 1'b0;
    end else begin
      cap_done_q <= cap_done_d;
      straps_q <= straps_d;
      rom_boot_q <= rom_boot_d;
    end
  end

  wire logic cap_pulse = ~cap_done_q;

  // ****************************************************************
  // ahb-lite register slave
  // ****************************************************************
  logic wr_pend_q, wr_pend_d;
  logic [13:0] wr_idx_q, wr_idx_d;
  logic [15:0] wait_ctrl_q, wait_ctrl_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [31:0] status_word;
  logic boot_done;
  logic addr_phase;
  logic [13:0] addr_idx;

  // only nonseq/seq transfers are taken; size is not checked,
  // the bus carries whole words only
  assign addr_phase = i_hsel & i_htrans[1] & i_hready;
  assign addr_idx = i_haddr[15:2];

  assign status_word = {27'h000_0000, boot_done, o_core_run,
                        straps_q, wait_ctrl_q[pm_map_pkg::ROM_SEL_POS]};

  // register next values; strap load beats a software write,
  // and no data phase can exist on the first edge after reset
  always_comb begin
    wr_pend_d = addr_phase & i_hwrite;
    wr_idx_d = addr_phase ? addr_idx : wr_idx_q;
    wait_ctrl_d = wait_ctrl_q;
    hrdata_d = pm_map_pkg::RDATA_RST;
    if (wr_pend_q && wr_idx_q == pm_map_pkg::WAIT_CTRL_IDX) begin
      wait_ctrl_d = i_hwdata[15:0];
    end
    if (cap_pulse) begin
      wait_ctrl_d[pm_map_pkg::ROM_SEL_POS] =
        i_memory_map_strap & i_boot_source_strap;
    end
    if (addr_phase && !i_hwrite) begin
      case (addr_idx)
        pm_map_pkg::WAIT_CTRL_IDX: begin
          hrdata_d = {16'h0000, wait_ctrl_q};
        end
        pm_map_pkg::STATUS_IDX: begin
          hrdata_d = status_word;
        end
        default: begin
          hrdata_d = pm_map_pkg::RDATA_RST; // unmapped reads zero
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 14'h0000;
      wait_ctrl_q <= pm_map_pkg::WAIT_CTRL_RST;
      hrdata_q <= pm_map_pkg::RDATA_RST;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      wait_ctrl_q <= wait_ctrl_d;
      hrdata_q <= hrdata_d;
    end
  end

  wire logic rom_select_bit = wait_ctrl_q[pm_map_pkg::ROM_SEL_POS];

  // ****************************************************************
  // boot loader, runs only when not booting from rom
  // ****************************************************************
  logic boot_rd;
  logic boot_we;
  logic [13:0] boot_baddr;
  logic [10:0] boot_waddr;
  logic [23:0] boot_word;
  logic boot_start;
  logic boot_busy_q, boot_busy_d;

  // mixed strap settings are treated like the all-zero map
  assign boot_start = cap_done_q & ~rom_boot_q & ~o_core_run
                      & ~boot_busy_q;

  // single start pulse; the loader never reruns before a reset
  always_comb begin
    boot_busy_d = boot_busy_q | boot_start;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_busy_q <= 1'b0;
    end else begin
      boot_busy_q <= boot_busy_d;
    end
  end

  pm_boot_loader u_boot (
    .i_core_clk (i_core_clk),
    .i_rst_b (i_rst_b),
    .i_start (boot_start),
    .i_ack (i_ext_ack),
    .i_byte (i_ext_byte),
    .o_rd (boot_rd),
    .o_byte_addr (boot_baddr),
    .o_we (boot_we),
    .o_word_addr (boot_waddr),
    .o_word (boot_word),
    .o_done (boot_done)
  );

  // ****************************************************************
  // core access decode
  // ****************************************************************
  pm_map_pkg::target_t core_tgt;

  pm_addr_decode u_decode (
    .i_addr (i_pm_addr),
    .i_rom_select_bit (rom_select_bit),
    .o_target (core_tgt)
  );

  // ****************************************************************
  // memory side outputs
  // ****************************************************************
  logic ram_en_d, rom_en_d, ext_en_d, boot_en_d, mem_wr_d;
  logic [13:0] mem_addr_d;
  logic [23:0] mem_wdata_d;
  logic run_d;
  logic [13:0] start_d;

  // the boot loader owns the buses until the core is released;
  // core requests before that are dropped, not queued
  always_comb begin
    ram_en_d = 1'b0;
    rom_en_d = 1'b0;
    ext_en_d = 1'b0;
    boot_en_d = 1'b0;
    mem_wr_d = 1'b0;
    mem_addr_d = o_mem_addr;
    mem_wdata_d = o_mem_wdata;
    if (!o_core_run) begin
      if (boot_rd) begin
        boot_en_d = 1'b1;
        mem_addr_d = boot_baddr;
      end else if (boot_we) begin
        ram_en_d = 1'b1;
        mem_wr_d = 1'b1;
        mem_addr_d = {3'b000, boot_waddr};
        mem_wdata_d = boot_word;
      end
    end else if (i_pm_req) begin
      mem_wr_d = i_pm_wr;
      mem_addr_d = i_pm_addr;
      mem_wdata_d = i_pm_wdata;
      case (core_tgt)
        pm_map_pkg::TGT_RAM: begin
          ram_en_d = 1'b1;
        end
        pm_map_pkg::TGT_ROM: begin
          rom_en_d = ~i_pm_wr; // rom ignores writes
        end
        pm_map_pkg::TGT_EXT: begin
          ext_en_d = 1'b1;
        end
        default: begin
          ext_en_d = 1'b0;
        end
      endcase
    end
  end

  // release of the core and its first fetch address
  always_comb begin
    run_d = o_core_run;
    start_d = o_start_addr;
    if (cap_done_q && !o_core_run) begin
      if (rom_boot_q) begin
        run_d = 1'b1;
        start_d = pm_map_pkg::ROM_BOOT_START;
      end else if (boot_done) begin
        run_d = 1'b1;
        start_d = pm_map_pkg::RAM_BOOT_START;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ram_en <= 1'b0;
      o_rom_en <= 1'b0;
      o_ext_en <= 1'b0;
      o_boot_en <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_addr <= pm_map_pkg::RAM_BASE;
      o_mem_wdata <= 24'h00_0000;
      o_core_run <= 1'b0;
      o_start_addr <= pm_map_pkg::RAM_BOOT_START;
    end else begin
      o_ram_en <= ram_en_d;
      o_rom_en <= rom_en_d;
      o_ext_en <= ext_en_d;
      o_boot_en <= boot_en_d;
      o_mem_wr <= mem_wr_d;
      o_mem_addr <= mem_addr_d;
      o_mem_wdata <= mem_wdata_d;
      o_core_run <= run_d;
      o_start_addr <= start_d;
    end
  end

  // ****************************************************************
  // bus answer, zero wait states
  // ****************************************************************
  logic hready_q;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hready_q <= 1'b0;
    end else begin
      hready_q <= 1'b1;
    end
  end

  assign o_hrdata = hrdata_q;
  assign o_hreadyout = hready_q;
  assign o_hresp = 1'b0;

endmodule // program_memory_map_decode
`default_nettype wire

/* File: pm_map_chk.sv */
// assertion checker for the program memory map decode
`timescale 1ns/1ps
`default_nettype none
module pm_map_chk (
  input wire logic i_core_clk, // clock
  input wire logic i_rst_b, // reset, low
  input wire logic i_memory_map_strap, // strap
  input wire logic i_boot_source_strap, // strap
  input wire logic i_hsel, // select
  input wire logic [15:0] i_haddr, // address
  input wire logic [1:0] i_htrans, // type
  input wire logic i_hwrite, // write
  input wire logic [31:0] i_hwdata, // data
  input wire logic i_hready, // ready
  input wire logic [31:0] o_hrdata, // read data
  input wire logic i_pm_req, // access
  input wire logic [13:0] i_pm_addr, // address
  input wire logic i_pm_wr, // write
  input wire logic o_ram_en, // ram
  input wire logic o_rom_en, // rom
  input wire logic o_ext_en, // external
  input wire logic [13:0] o_mem_addr, // address
  input wire logic o_core_run, // run
  input wire logic [13:0] o_start_addr // start
);
  logic started_q, first_q, both_q, sel_q, wr_ph_q, rd_ph_q;
  logic take, acc, in_rom;
  assign take = i_hsel && i_htrans[1] && i_hready
    && (i_haddr == pm_map_pkg::WAIT_CTRL_ADDR);
  assign acc = i_pm_req && o_core_run;
  assign in_rom = (i_pm_addr >= pm_map_pkg::ROM_BASE)
    && (i_pm_addr <= pm_map_pkg::ROM_LAST);
  // shadow of the rom bit: straps load on the first edge, then writes
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      started_q <= 1'b0;
      first_q <= 1'b0;
      both_q <= 1'b0;
      sel_q <= 1'b0;
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
      first_q <= !started_q;
      wr_ph_q <= take && i_hwrite;
      rd_ph_q <= take && !i_hwrite;
      if (!started_q) begin
        both_q <= i_memory_map_strap && i_boot_source_strap;
        sel_q <= i_memory_map_strap && i_boot_source_strap;
      end else if (wr_ph_q) begin
        sel_q <= i_hwdata[15];
      end
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // routing of core accesses
  a_rom_route: assert property (acc && in_rom && sel_q && !i_pm_wr |=>
    o_rom_en && !o_ext_en && o_mem_addr == $past(i_pm_addr))
    else $error("rom window read missed rom");
  a_ext_route: assert property (acc && in_rom && !sel_q |=>
    o_ext_en && !o_rom_en) else $error("rom window not external");
  a_ext_upper: assert property (acc && i_pm_addr >= 14'h1000 |=>
    o_ext_en && o_mem_addr == $past(i_pm_addr))
    else $error("upper space not external");
  a_ram_low: assert property (acc && i_pm_addr <= 14'h07ff |=>
    o_ram_en && !o_rom_en && !o_ext_en) else $error("low space not ram");
  a_rom_wr_drop: assert property (acc && in_rom && sel_q && i_pm_wr |=>
    !(o_ram_en || o_rom_en || o_ext_en)) else $error("rom write strobed");
  // start of execution after reset; rom bit readback
  a_rom_start: assert property (first_q && both_q |-> ##1
    (o_core_run && o_start_addr == 14'h0800)) else $error("rom start wrong");
  a_ram_hold: assert property (first_q && !both_q |->
    ##1 (!o_core_run) [*8]) else $error("run before boot load");
  a_reg_read: assert property (rd_ph_q |->
    o_hrdata[15] == sel_q && o_hrdata[31:16] == 16'h0000)
    else $error("rom bit readback wrong");
endmodule // pm_map_chk
bind program_memory_map_decode pm_map_chk u_chk (
  .i_core_clk, .i_rst_b, .i_memory_map_strap, .i_boot_source_strap,
  .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready,
  .o_hrdata, .i_pm_req, .i_pm_addr, .i_pm_wr, .o_ram_en, .o_rom_en,
  .o_ext_en, .o_mem_addr, .o_core_run, .o_start_addr
);
`default_nettype wire

/* File: boot_byte_src.sv */
// external byte-wide boot source model
`timescale 1ns/1ps
`default_nettype none
module boot_byte_src (
  input wire logic i_core_clk, // clock
  input wire logic i_rst_b, // reset, low
  input wire logic i_boot_en, // byte read strobe
  input wire logic [13:0] i_byte_addr, // byte address
  output logic o_ack, // byte returned
  output logic [7:0] o_byte // byte data
);
  logic [13:0] addr_q;
  logic [1:0] wait_q;
  logic busy_q;
  // latency of one to four cycles; idle data toggles so stale bytes show
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_q <= 1'b0;
      addr_q <= 14'h0000;
      wait_q <= 2'h0;
      o_ack <= 1'b0;
      o_byte <= 8'h00;
    end else begin
      o_ack <= 1'b0;
      o_byte <= ~o_byte;
      if (i_boot_en) begin
        busy_q <= 1'b1;
        addr_q <= i_byte_addr;
        wait_q <= i_byte_addr[1:0] ^ i_byte_addr[4:3];
      end else if (busy_q && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        o_ack <= 1'b1;
        o_byte <= addr_q[7:0] ^ {2'h0, addr_q[13:8]} ^ 8'ha5;
      end
    end
  end
endmodule // boot_byte_src
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the program memory map decode
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic map_s, boot_s, hsel, hwrite, pm_req, pm_wr, rom_m;
  logic ready, ram_en, rom_en, ext_en, boot_en, mem_wr, run, ack, hresp;
  logic [15:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, hr_s, lfsr;
  logic [31:0] wv [3] = '{32'h0000_1234, 32'hffff_a5c3, 32'h5a5a_0f0f};
  logic [13:0] pm_addr, mem_addr, start;
  logic [13:0] tbl [8] = '{14'h0000, 14'h07ff, 14'h0800, 14'h0abc,
    14'h0fff, 14'h1000, 14'h3fff, 14'h2345};
  logic [23:0] pm_wdata, mem_wdata;
  logic [7:0] ebyte;
  logic [41:0] exp_q [$];
  logic [41:0] e_m;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  program_memory_map_decode u_dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_memory_map_strap(map_s),
    .i_boot_source_strap(boot_s), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(ready), .o_hrdata(hrdata),
    .o_hreadyout(ready), .o_hresp(hresp), .i_pm_req(pm_req),
    .i_pm_addr(pm_addr), .i_pm_wr(pm_wr), .i_pm_wdata(pm_wdata),
    .o_ram_en(ram_en), .o_rom_en(rom_en), .o_ext_en(ext_en),
    .o_boot_en(boot_en), .o_mem_wr(mem_wr), .o_mem_addr(mem_addr),
    .o_mem_wdata(mem_wdata), .i_ext_ack(ack), .i_ext_byte(ebyte),
    .o_core_run(run), .o_start_addr(start));
  boot_byte_src u_src (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_boot_en(boot_en), .i_byte_addr(mem_addr), .o_ack(ack),
    .o_byte(ebyte));
  initial forever #10 clk = ~clk;
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] img(input int a);
    return a[7:0] ^ {2'h0, a[13:8]} ^ 8'ha5;
  endfunction
  // strobe kind {ram, rom, ext}: rom window follows the rom bit
  function automatic logic [2:0] route(input logic [13:0] a);
    if (a <= 14'h07ff) return 3'b100;
    if (a >= 14'h1000 || !rom_m) return 3'b001;
    return 3'b010;
  endfunction
  task automatic chk(input logic [41:0] g, input logic [41:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // single word transfer; read data is taken on the falling edge inside the data phase
  task automatic ahb(input logic w, input logic [15:0] a,
      input logic [31:0] d, input logic [31:0] e);
    lfsr = nxt(lfsr);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= w ? d : lfsr;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    if (!w) chk({9'h0, hresp, hr_s}, {10'h0, e});
  endtask
  // one core access per cycle; rom writes expect no strobe
  task automatic acc(input logic [13:0] a, input logic w);
    lfsr = nxt(lfsr);
    pm_req <= 1'b1;
    pm_addr <= a;
    pm_wr <= w;
    pm_wdata <= lfsr[23:0];
    if (!(w && route(a) == 3'b010))
      exp_q.push_back({route(a), w, a, w ? lfsr[23:0] : 24'h0});
    @(posedge clk);
  endtask
  task automatic sweep;
    for (int i = 0; i < 16; i++) acc(tbl[i % 8], i >= 8);
    for (int i = 0; i < 12; i++) acc(lfsr[13:0], lfsr[20]);
    pm_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk(42'(exp_q.size()), 42'h0);
  endtask
  task automatic reset_to(input logic m, input logic b);
    rst_b <= 1'b0;
    map_s <= m;
    boot_s <= b;
    rom_m = m & b;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // strobe watcher retires the oldest noted access per strobe
  always @(negedge clk) begin
    hr_s <= hrdata;
    if (ram_en || rom_en || ext_en) begin
      e_m = (exp_q.size() > 0) ? exp_q.pop_front() : 42'h0;
      chk({ram_en, rom_en, ext_en, mem_wr, mem_addr,
        e_m[38] ? mem_wdata : 24'h0}, e_m);
    end
  end
  // hang guard, well above the boot load and sweeps
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    {map_s, boot_s, hsel, hwrite, pm_req, pm_wr} = 6'h00;
    {haddr, htrans, pm_addr, pm_wdata} = 56'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    lfsr = 32'h671e;
    for (int w = 0; w < 2048; w++)
      exp_q.push_back({4'h9, w[13:0], img(3*w), img(3*w+1), img(3*w+2)});
    reset_to(1'b0, 1'b0);
    while (run !== 1'b1) @(negedge clk);
    chk({28'h0, start}, 42'h0);
    chk(42'(exp_q.size()), 42'h0);
    @(posedge clk);
    $display("test ram boot done");
    ahb(1'b0, 16'hfff8, 32'h0, 32'h0);
    ahb(1'b0, 16'hfffc, 32'h0, 32'h18);
    for (int k = 0; k < 3; k++) begin
      ahb(1'b1, 16'hfff8, wv[k], 32'h0);
      rom_m = wv[k][15];
      ahb(1'b0, 16'hfff8, 32'h0, {16'h0, wv[k][15:0]});
      sweep();
    end
    ahb(1'b1, 16'h0100, 32'hffff_ffff, 32'h0);
    ahb(1'b0, 16'h0100, 32'h0, 32'h0);
    ahb(1'b1, 16'hfffc, 32'hffff_ffff, 32'h0);
    ahb(1'b0, 16'hfffc, 32'h0, 32'h18);
    $display("test decode and registers done");
    reset_to(1'b1, 1'b0);
    ahb(1'b0, 16'hfff8, 32'h0, 32'h0);
    chk({41'h0, run}, 42'h0);
    reset_to(1'b1, 1'b1);
    @(negedge clk);
    chk({27'h0, run, start}, {28'h1, 14'h0800});
    @(posedge clk);
    ahb(1'b0, 16'hfff8, 32'h0, 32'h8000);
    sweep();
    $display("test rom boot done");
    summarize();
  end
endmodule // tb
`default_nettype wire
